//--- include/can_cfg_pkg.sv
// Constants for the CAN bit timing and acceptance filter configuration block.
// Assumes a 16-bit register port with word indices as addresses.
package can_cfg_pkg;
  // Register word indices
  localparam logic [4:0] ADDR_TIMING   = 5'h00;
  localparam logic [4:0] ADDR_BP_4_7   = 5'h01;
  localparam logic [4:0] ADDR_BP_8_11  = 5'h02;
  localparam logic [4:0] ADDR_STATUS   = 5'h03;
  localparam logic [4:0] ADDR_FILT_0   = 5'h10;
  // Timing register fields
  localparam int WAKE_BIT     = 14;
  localparam int PH2_MSB      = 10;
  localparam int PH2_LSB      = 8;
  localparam int PH2_SEL_BIT  = 7;
  localparam int SAMPLE_BIT   = 6;
  localparam int PH1_MSB      = 5;
  localparam int PH1_LSB      = 3;
  localparam int PROP_MSB     = 2;
  localparam int PROP_LSB     = 0;
  localparam logic [15:0] TIMING_WMASK = 16'h47ff;
  // Filter identifier fields
  localparam int STD_MSB      = 15;
  localparam int STD_LSB      = 5;
  localparam int EXT_SEL_BIT  = 3;
  localparam logic [15:0] FILT_WMASK = 16'hffeb;
  // Reset values and FIFO pointer code
  localparam logic [15:0] BP_RESET   = 16'h0000;
  localparam logic [15:0] UNDEF_INIT = 16'h0000;
  localparam logic [3:0]  BP_FIFO    = 4'hf;
  // Information processing time in quanta
  localparam logic [3:0]  PROC_QUANTA = 4'h2;
  // Line filter length in clocks
  localparam logic [3:0]  LINE_FILT_LEN = 4'h8;
endpackage

//--- rtl/can_line_filter.sv
// Glitch filter on the synchronised CAN receive line.
// Assumes the input already passed a two-flop synchroniser.
`timescale 1ns/1ps
`default_nettype none
module can_line_filter
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // Line
  input  wire logic       line_in,
  input  wire logic [3:0] filt_len,
  output logic            line_out
);
  import can_cfg_pkg::*;

  typedef struct packed
  {
    logic [3:0] cnt;
    logic       level;
  } filt_state_t;

  filt_state_t state;
  filt_state_t next_state;

  // Accept a new level only after it holds filt_len plus one clocks
  always_comb
  begin
    next_state = state;
    if (line_in == state.level)
      next_state.cnt = 4'h0;
    else if (state.cnt >= filt_len)
    begin
      next_state.level = line_in;
      next_state.cnt   = 4'h0;
    end
    else
      next_state.cnt = state.cnt + 4'h1;
  end

  // State register, recessive after reset
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      state <= '{cnt: 4'h0, level: 1'b1};
    else
      state <= next_state;
  end

  assign line_out = state.level;
endmodule // can_line_filter
`default_nettype wire

//--- rtl/can_cfg_core.sv
// CAN bit timing, wake-up, buffer pointer and acceptance filter logic.
// Assumes a synchronous register port and a quantum tick from elsewhere.
//
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module can_cfg_core
#(
  parameter int NUM_FILTERS = 16
)
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Register port
  input  wire logic [4:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata,
  // Bus line and time quantum tick
  input  wire logic        can_rx,
  input  wire logic        tq_tick,
  input  wire logic        bus_sleep,
  output logic             wake_detect,
  output logic             sampled_bit,
  output logic             sample_strobe,
  // Received identifier to match
  input  wire logic        match_req,
  input  wire logic [10:0] rx_std_id,
  input  wire logic [1:0]  rx_ext_hi,
  input  wire logic        rx_is_ext,
  input  wire logic [10:0] mask_std,
  input  wire logic [1:0]  mask_ext_hi,
  input  wire logic        mask_frame_type_enable,
  output logic             match_valid,
  output logic [15:0]      match_hits,
  output logic [3:0]       match_filter,
  output logic             match_found,
  output logic [3:0]       match_dest,
  output logic             match_to_fifo
);
  import can_cfg_pkg::*;

  // Bit segments, one-hot
  typedef enum logic [3:0]
  {
    SEG_SYNC  = 4'b0001,
    SEG_PROP  = 4'b0010,
    SEG_PH1   = 4'b0100,
    SEG_PH2   = 4'b1000
  } seg_t;

  // All registered state of the block
  typedef struct packed
  {
    logic [15:0]     timing;
    logic [15:0]     bp_4_7;
    logic [15:0]     bp_8_11;
    logic [15:0][15:0] filt;
    logic [15:0]     rdata;
    logic [1:0]      rx_sync;
    logic [2:0]      samples;
    seg_t            seg;
    logic [3:0]      seg_cnt;
    logic            bit_val;
    logic            strobe;
    logic            wake;
    logic            m_valid;
    logic [15:0]     m_hits;
    logic [3:0]      m_filt;
    logic            m_found;
    logic [3:0]      m_dest;
    logic            m_fifo;
  } core_state_t;

  core_state_t state;
  core_state_t next_state;
  logic        rx_line;
  logic        rx_filtered;
  logic        wake_line;
  logic [3:0]  prop_q;
  logic [3:0]  ph1_q;
  logic [3:0]  ph2_q;
  logic [15:0] hits;
  logic [3:0]  first_hit;
  logic        any_hit;
  logic [3:0]  dest;
  logic [3:0]  filt_dest [16];
  logic        filt_sel;
  logic [15:0] status;

  // Synchronised bus line
  // Only the second flop feeds logic, against metastability
  assign rx_line = state.rx_sync[1];

  // Line glitch filter used on the wake path
  // With the wake filter bit set, a glitch shorter than the filter length never wakes the node
  can_line_filter u_line_filter
  (
    .clk      (clk),
    .arst_n   (arst_n),
    .line_in  (rx_line),
    .filt_len (LINE_FILT_LEN),
    .line_out (rx_filtered)
  );

  // Wake path selects filtered or raw line
  assign wake_line = state.timing[WAKE_BIT] ? rx_filtered : rx_line;

  // Segment lengths in quanta
  // Four bits hold 8 quanta, so field plus one never wraps
  assign prop_q = {1'b0, state.timing[PROP_MSB:PROP_LSB]} + 4'h1;
  assign ph1_q  = {1'b0, state.timing[PH1_MSB:PH1_LSB]} + 4'h1;
  // Derived phase 2 never shorter than the processing time after sampling; a programmed phase 2 can be one quantum
  always_comb
  begin
    if (state.timing[PH2_SEL_BIT])
      ph2_q = {1'b0, state.timing[PH2_MSB:PH2_LSB]} + 4'h1;
    else
      ph2_q = (ph1_q > PROC_QUANTA) ? ph1_q : PROC_QUANTA;
  end

  // Per-filter compare against the received identifier
  // A mask bit of one makes that identifier bit take part
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++)
    begin : g_filt
      logic std_ok;
      logic ext_ok;
      logic typ_ok;
      assign std_ok = ((rx_std_id ^ state.filt[gi][STD_MSB:STD_LSB]) & mask_std)
                      == 11'h000;
      assign ext_ok = ((rx_ext_hi ^ state.filt[gi][1:0]) & mask_ext_hi)
                      == 2'b00;
      assign typ_ok = !mask_frame_type_enable
                      || (state.filt[gi][EXT_SEL_BIT] == rx_is_ext);
      assign hits[gi] = (gi < NUM_FILTERS) && std_ok && typ_ok
                        && (!rx_is_ext || ext_ok);
    end
  endgenerate

  // Lowest numbered hit wins
  // Counting down leaves the lowest hit as the last one written
  always_comb
  begin
    first_hit = 4'h0;
    any_hit   = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      if (hits[i])
      begin
        first_hit = i[3:0];
        any_hit   = 1'b1;
      end
    end
  end

  // Pointer nibble per filter; filters without a pointer go to the FIFO
  genvar gp;
  generate
    for (gp = 0; gp < 16; gp++)
    begin : g_dest
      if (gp >= 4 && gp < 8)
      begin : g_low
        assign filt_dest[gp] = state.bp_4_7[4 * (gp - 4) +: 4];
      end
      else if (gp >= 8 && gp < 12)
      begin : g_high
        assign filt_dest[gp] = state.bp_8_11[4 * (gp - 8) +: 4];
      end
      else
      begin : g_none
        assign filt_dest[gp] = BP_FIFO;
      end
    end
  endgenerate

  // Destination of the winning filter
  assign dest = filt_dest[first_hit];

  // Filter window, limited to the filters built
  assign filt_sel = reg_addr[4] && (int'(reg_addr[3:0]) < NUM_FILTERS);

  // Status word shows live segment, last sample and wake
  // Status is read only; writes to its index are dropped
  assign status = {8'h00, state.seg, 1'b0, state.wake, state.bit_val, rx_line};

  // Next state of all registers
  always_comb
  begin
    next_state         = state;
    next_state.rx_sync = {state.rx_sync[0], can_rx};
    // Pulses drop each cycle unless raised below
    next_state.strobe  = 1'b0;
    next_state.m_valid = 1'b0;
    next_state.wake    = bus_sleep && !wake_line;

    // Register writes
    if (reg_wr)
    begin
      case (reg_addr)
        ADDR_TIMING:  next_state.timing  = reg_wdata & TIMING_WMASK;
        ADDR_BP_4_7:  next_state.bp_4_7  = reg_wdata;
        ADDR_BP_8_11: next_state.bp_8_11 = reg_wdata;
        default:
        begin
          if (filt_sel)
            next_state.filt[reg_addr[3:0]] = reg_wdata & FILT_WMASK;
        end
      endcase
    end

    // Register reads, data one cycle later
    next_state.rdata = 16'h0000;
    if (reg_rd)
    begin
      case (reg_addr)
        ADDR_TIMING:  next_state.rdata = state.timing;
        ADDR_BP_4_7:  next_state.rdata = state.bp_4_7;
        ADDR_BP_8_11: next_state.rdata = state.bp_8_11;
        ADDR_STATUS:  next_state.rdata = status;
        default:
        begin
          if (filt_sel)
            next_state.rdata = state.filt[reg_addr[3:0]];
        end
      endcase
    end

    // Bit timing walk, one step per quantum
    if (tq_tick)
    begin
      next_state.seg_cnt = state.seg_cnt + 4'h1;
      case (state.seg)
        SEG_SYNC:
        begin
          next_state.seg     = SEG_PROP;
          next_state.seg_cnt = 4'h1;
        end
        SEG_PROP:
        begin
          if (state.seg_cnt >= prop_q)
          begin
            next_state.seg     = SEG_PH1;
            next_state.seg_cnt = 4'h1;
          end
        end
        SEG_PH1:
        begin
          // Collect samples in the last quanta of phase 1
          // A phase 1 under three quanta reuses samples of the bit before
          next_state.samples = {state.samples[1:0], rx_line};
          if (state.seg_cnt >= ph1_q)
          begin
            next_state.seg     = SEG_PH2;
            next_state.seg_cnt = 4'h1;
            next_state.strobe  = 1'b1;
            if (state.timing[SAMPLE_BIT])
              next_state.bit_val = (state.samples[1] & state.samples[0])
                                   | (state.samples[1] & rx_line)
                                   | (state.samples[0] & rx_line);
            else
              next_state.bit_val = rx_line;
          end
        end
        SEG_PH2:
        begin
          if (state.seg_cnt >= ph2_q)
          begin
            next_state.seg     = SEG_SYNC;
            next_state.seg_cnt = 4'h0;
          end
        end
        default:
        begin
          next_state.seg     = SEG_SYNC;
          next_state.seg_cnt = 4'h0;
        end
      endcase
    end

    // Filter match result
    if (match_req)
    begin
      next_state.m_valid = 1'b1;
      next_state.m_hits  = hits;
      next_state.m_filt  = first_hit;
      next_state.m_found = any_hit;
      next_state.m_dest  = dest;
      next_state.m_fifo  = any_hit && (dest == BP_FIFO);
    end
  end

  // Timing and identifiers have no defined reset meaning
  // Line path starts recessive so no false bit follows reset
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state         <= '0;
      state.timing  <= UNDEF_INIT;
      state.bp_4_7  <= BP_RESET;
      state.bp_8_11 <= BP_RESET;
      state.rx_sync <= 2'b11;
      state.samples <= 3'b111;
      state.bit_val <= 1'b1;
      state.seg     <= SEG_SYNC;
    end
    else
      state <= next_state;
  end

  // Outputs from flip-flops
  // Read data is zero outside its one-cycle slot
  assign reg_rdata     = state.rdata;
  assign wake_detect   = state.wake;
  assign sampled_bit   = state.bit_val;
  assign sample_strobe = state.strobe;
  assign match_valid   = state.m_valid;
  assign match_hits    = state.m_hits;
  assign match_filter  = state.m_filt;
  assign match_found   = state.m_found;
  assign match_dest    = state.m_dest;
  assign match_to_fifo = state.m_fifo;
endmodule // can_cfg_core
`default_nettype wire

//--- sim/can_cfg_checker.sv
// Port checker for the CAN timing and filter configuration core.
// Assumes it is bound onto can_cfg_core and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module can_cfg_checker
#(
  parameter int NUM_FILTERS = 16
)
(
  // Clock, reset and register read
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  // Timing and wake
  input wire logic        tq_tick,
  input wire logic        bus_sleep,
  input wire logic        wake_detect,
  input wire logic        sampled_bit,
  input wire logic        sample_strobe,
  // Match results
  input wire logic        match_req,
  input wire logic        match_valid,
  input wire logic        match_found,
  input wire logic [15:0] match_hits,
  input wire logic [3:0]  match_filter,
  input wire logic [3:0]  match_dest
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // Register port, match pipeline, timing and wake relations
  a_rdata_slot: assert property (reg_rdata != 16'h0000 |-> $past(reg_rd))
    else $error("read data outside its slot");
  a_valid_pulse: assert property (match_req |=> match_valid)
    else $error("no result after compare request");
  a_result_hold: assert property (!match_valid |->
    $stable({match_hits, match_filter, match_found, match_dest}))
    else $error("result moved without request");
  a_lowest_hit: assert property (match_valid && match_found |-> match_hits[match_filter] &&
    ((match_hits & ((16'h0001 << match_filter) - 16'h0001)) == 16'h0000))
    else $error("reported filter is not lowest hit");
  a_outer_fifo: assert property (match_valid && match_found &&
    (match_filter < 4'h4 || match_filter > 4'hb) |-> match_dest == 4'hf)
    else $error("unpointed filter not sent to fifo");
  a_strobe_tick: assert property (sample_strobe |->
    $past(tq_tick) ##1 !sample_strobe [*3])
    else $error("sample strobe off a quantum boundary");
  a_bit_strobe: assert property ($changed(sampled_bit) |-> sample_strobe)
    else $error("sampled bit changed without strobe");
  a_wake_sleep: assert property (wake_detect |-> $past(bus_sleep))
    else $error("wake outside sleep");
endmodule // can_cfg_checker
bind can_cfg_core can_cfg_checker #(.NUM_FILTERS(NUM_FILTERS)) chk
(
  .clk(clk), .arst_n(arst_n), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tq_tick(tq_tick),
  .bus_sleep(bus_sleep), .wake_detect(wake_detect), .sampled_bit(sampled_bit),
  .sample_strobe(sample_strobe), .match_req(match_req), .match_valid(match_valid),
  .match_found(match_found), .match_hits(match_hits), .match_filter(match_filter),
  .match_dest(match_dest)
);
`default_nettype wire

//--- sim/can_node_model.sv
// Bus node model standing on the far side of the receive line.
// Assumes the bench commands when some node drives the bus dominant.
`timescale 1ns/1ps
`default_nettype none
module can_node_model
(
  // Clock
  input  wire logic clk,
  // Command: a node drives dominant
  input  wire logic dominant,
  // Receive line, recessive high when idle
  output logic      can_rx
);
  // Transceiver output, one clock behind the bus
  initial
  begin
    can_rx = 1'b1;
  end
  always @(posedge clk)
  begin
    can_rx <= ~dominant;
  end
endmodule // can_node_model
`default_nettype wire

//--- sim/can_bit_timing_filter_config_bench.sv
// Self-checking bench for the CAN timing and filter configuration core.
// Assumes the core package, the bus node model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module can_bit_timing_filter_config_bench;
  import can_cfg_pkg::*;
  // Stimulus and observed signals
  logic clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, tq_tick = 1'b0;
  logic bus_sleep = 1'b0, dominant = 1'b0, match_req = 1'b0, rx_is_ext = 1'b0, mte = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, match_hits, bp2, bp3;
  logic [10:0] rx_std_id = 11'h000, mask_std = 11'h000;
  logic [1:0] rx_ext_hi = 2'h0, mask_ext_hi = 2'h0;
  logic [3:0] match_filter, match_dest;
  logic can_rx, wake_detect, sampled_bit, sample_strobe, match_valid, match_found, match_to_fifo;
  logic [15:0] filt [16];
  int fails = 0, samples_checked = 0, cycles = 0;

  can_cfg_core uut
  (
    .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .can_rx(can_rx),
    .tq_tick(tq_tick), .bus_sleep(bus_sleep), .wake_detect(wake_detect),
    .sampled_bit(sampled_bit), .sample_strobe(sample_strobe), .match_req(match_req),
    .rx_std_id(rx_std_id), .rx_ext_hi(rx_ext_hi), .rx_is_ext(rx_is_ext), .mask_std(mask_std),
    .mask_ext_hi(mask_ext_hi), .mask_frame_type_enable(mte), .match_valid(match_valid),
    .match_hits(match_hits), .match_filter(match_filter), .match_found(match_found),
    .match_dest(match_dest), .match_to_fifo(match_to_fifo)
  );
  can_node_model node
  (
    .clk(clk), .dominant(dominant), .can_rx(can_rx)
  );

  // Clock, quantum tick every other cycle, run limit
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    tq_tick <= ~tq_tick;
    cycles <= cycles + 1;
    if (cycles == 8000)
    begin
      fails++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (fails == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Writes may follow each other; a read always closes a sequence
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    reg_addr <= a;
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    check(reg_rdata, exp);
  endtask
  // One compare with random masks around filter k
  task automatic match(input int k);
    logic [15:0] h, g;
    int f;
    rx_std_id <= $urandom_range(1) ? filt[k][15:5] : 11'($urandom());
    rx_ext_hi <= $urandom_range(1) ? filt[k][1:0] : 2'($urandom());
    rx_is_ext <= 1'($urandom());
    mask_std <= 11'($urandom());
    mask_ext_hi <= 2'($urandom());
    mte <= 1'($urandom());
    match_req <= 1'b1;
    @(posedge clk);
    match_req <= 1'b0;
    for (int n = 0; n < 16; n++)
      h[n] = (((filt[n][15:5] ^ rx_std_id) & mask_std) == 11'h000) &&
        (!rx_is_ext || (((filt[n][1:0] ^ rx_ext_hi) & mask_ext_hi) == 2'h0)) &&
        (!mte || filt[n][3] == rx_is_ext);
    @(posedge clk);
    check({15'h0, match_valid}, 16'h0001);
    check(match_hits, h);
    check({15'h0, match_found}, {15'h0, h != 16'h0000});
    if (h != 16'h0000)
    begin
      f = 0;
      while (!h[f])
        f++;
      g = f < 4 || f > 11 ? 16'(BP_FIFO) : (f < 8 ? bp2 : bp3) >> (4 * (f % 4));
      g = g & 16'h000f;
      check({12'h0, match_filter}, 16'(f));
      check({12'h0, match_dest}, g);
      check({15'h0, match_to_fifo}, {15'h0, g == 16'h000f});
    end
  endtask
  // Strobe period and sampled level for one timing setting
  task automatic bit_time(input logic [15:0] d);
    int t, n;
    dominant <= 1'($urandom());
    wr(ADDR_TIMING, d);
    rd(ADDR_TIMING, d & TIMING_WMASK);
    t = 3 + d[2:0] + d[5:3];
    t += d[7] ? d[10:8] + 1 : (d[5:3] + 1 > PROC_QUANTA ? d[5:3] + 1 : PROC_QUANTA);
    n = 0;
    repeat (2)
    begin
      @(posedge clk);
      while (sample_strobe !== 1'b1)
        @(posedge clk);
    end
    do
    begin
      @(posedge clk);
      n++;
    end
    while (sample_strobe !== 1'b1);
    check(16'(n), 16'(2 * t));
    check({15'h0, sampled_bit}, {15'h0, ~dominant});
  endtask

  // Main sequence
  initial
  begin
    void'($urandom(10885));
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rd(ADDR_BP_4_7, BP_RESET);
    rd(ADDR_BP_8_11, BP_RESET);
    rd(ADDR_TIMING, UNDEF_INIT);
    rd(ADDR_FILT_0, UNDEF_INIT);
    bp2 = {BP_FIFO, 12'($urandom())};
    bp3 = 16'($urandom()) & 16'hfff0;
    wr(ADDR_BP_4_7, bp2);
    wr(ADDR_BP_8_11, bp3);
    rd(ADDR_BP_4_7, bp2);
    rd(ADDR_BP_8_11, bp3);
    for (int n = 0; n < 16; n++)
    begin
      filt[n] = 16'($urandom());
      wr(ADDR_FILT_0 + 5'(n), filt[n]);
      filt[n] &= FILT_WMASK;
    end
    wr(5'h08, 16'hffff);
    rd(5'h08, 16'h0000); // Unmapped index reads zero
    for (int n = 0; n < 16; n++)
      rd(ADDR_FILT_0 + 5'(n), filt[n]);
    repeat (60) match($urandom_range(15));
    bit_time(16'h0000);
    bit_time(16'hffff);
    repeat (3) bit_time(16'($urandom()));
    dominant <= 1'b0;
    repeat (16) @(posedge clk);
    // Wake with line filter on (glitch ignored), then off
    for (int w = 1; w >= 0; w--)
    begin
      wr(ADDR_TIMING, 16'(w) << WAKE_BIT);
      rd(ADDR_TIMING, 16'(w) << WAKE_BIT);
      bus_sleep <= 1'b1;
      dominant <= w[0];
      @(posedge clk);
      dominant <= 1'b0;
      repeat (12)
      begin
        @(posedge clk);
        check({15'h0, wake_detect}, 16'h0000);
      end
      dominant <= 1'b1;
      repeat (6) @(posedge clk);
      check({15'h0, wake_detect}, {15'h0, !w[0]});
      repeat (14) @(posedge clk);
      check({15'h0, wake_detect}, 16'h0001);
      bus_sleep <= 1'b0;
      dominant <= 1'b0;
      repeat (3) @(posedge clk);
      check({15'h0, wake_detect}, 16'h0000);
    end
    stop_test();
  end
endmodule // can_bit_timing_filter_config_bench
`default_nettype wire
